// >>> pkg/drrcl_pkg.sv
// Constants shared by the range and gain configuration host controller.
// Assumes a 40 MHz pclk and an APB master with 32-bit data.
package drrcl_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] DRRCL_OFF_CTRL = 8'h00;
	localparam logic [7:0] DRRCL_OFF_STATUS = 8'h04;
	localparam logic [7:0] DRRCL_OFF_CONFIG = 8'h08;
	localparam logic [7:0] DRRCL_OFF_FIRST = 8'h0c;
	localparam logic [7:0] DRRCL_OFF_APPLIED = 8'h10;
	localparam int DRRCL_CMD_LSB = 0;
	localparam int DRRCL_ST_BUSY = 0;
	localparam int DRRCL_ST_REFUSED = 1;
	localparam int DRRCL_ST_DONE = 2;
	localparam logic [7:0] DRRCL_CONFIG_RST = 8'h00;

	// ==========================================================
	// Commands written to the control register
	typedef enum logic [1:0]
	{
		DRRCL_CMD_NONE,
		DRRCL_CMD_LOAD_UPDATE,
		DRRCL_CMD_PRELOAD,
		DRRCL_CMD_UPDATE
	} drrcl_cmd_e;

	// ==========================================================
	// Pin timing, worst case over temperature
	localparam int DRRCL_CLK_NS = 25;
	localparam int DRRCL_LS_LOW_NS = 70;
	localparam int DRRCL_LS_TO_CS_NS = 80;
	localparam int DRRCL_CS_LOW_NS = 100;
	localparam int DRRCL_HOLD_NS = 15;
	localparam int DRRCL_LEAD_NS = 25;
	localparam int DRRCL_LS_LOW_CYC =
		(DRRCL_LS_LOW_NS + DRRCL_CLK_NS - 1) / DRRCL_CLK_NS;
	localparam int DRRCL_LS_TO_CS_CYC =
		(DRRCL_LS_TO_CS_NS + DRRCL_CLK_NS - 1) / DRRCL_CLK_NS;
	localparam int DRRCL_CS_LOW_CYC =
		(DRRCL_CS_LOW_NS + DRRCL_CLK_NS - 1) / DRRCL_CLK_NS;
	localparam int DRRCL_HOLD_CYC =
		(DRRCL_HOLD_NS + DRRCL_CLK_NS - 1) / DRRCL_CLK_NS;
	localparam int DRRCL_LEAD_CYC =
		(DRRCL_LEAD_NS + DRRCL_CLK_NS - 1) / DRRCL_CLK_NS;
	localparam logic [3:0] DRRCL_CNT_RST = 4'h0;

endpackage

// >>> design/drrcl_host.sv
// Host controller that loads the range and gain configuration word into
// a dual-rank configuration latch through its strobe pins.
// Assumes software on APB, and that the latch sees the pins unregistered.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Config word rides top eight data lines.
// - Word, word select low (rank select too, except on update), then device select.
// - Device select rises after rank select on load-update.
// - Later update strobe moves preloaded word.
// - Rank select lead lengthens its pulse.
module drrcl_host
	import drrcl_pkg::*;
#(
	parameter int DATA_W = 12,
	parameter int CFG_W = 8
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Latch pins
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	output logic config_word_sel_n,
	output logic latch_rank_sel_n,
	output logic device_sel_n
);
	import drrcl_pkg::*;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_SETUP,
		ST_CS_LOW,
		ST_LS_HIGH,
		ST_HOLD
	} drrcl_state_e;

	drrcl_state_e state_q;
	drrcl_cmd_e cmd_q;
	logic [3:0] cnt_q;
	logic [CFG_W-1:0] config_q;
	logic [CFG_W-1:0] first_q;
	logic [CFG_W-1:0] applied_q;
	logic refused_q;
	logic done_q;
	logic busy;
	logic wr_en;
	logic rd_en;
	logic start;
	logic st_clear;
	logic mapped;
	drrcl_cmd_e wr_cmd;

	// ==========================================================
	// APB slave: zero wait states, error on unmapped offsets
	assign busy = (state_q != ST_IDLE);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr == DRRCL_OFF_CTRL) ||
		(paddr == DRRCL_OFF_STATUS) || (paddr == DRRCL_OFF_CONFIG) ||
		(paddr == DRRCL_OFF_FIRST) || (paddr == DRRCL_OFF_APPLIED);
	assign pslverr = psel && penable && !mapped;
	assign wr_cmd = drrcl_cmd_e'(pwdata[DRRCL_CMD_LSB +: 2]);
	assign start = wr_en && (paddr == DRRCL_OFF_CTRL) && !busy &&
		(wr_cmd != DRRCL_CMD_NONE);
	assign st_clear = wr_en && (paddr == DRRCL_OFF_STATUS);

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_en)
		begin
			case (paddr)
				DRRCL_OFF_CTRL: prdata[1:0] = cmd_q;
				DRRCL_OFF_STATUS:
				begin
					prdata[DRRCL_ST_BUSY] = busy;
					prdata[DRRCL_ST_REFUSED] = refused_q;
					prdata[DRRCL_ST_DONE] = done_q;
				end
				DRRCL_OFF_CONFIG: prdata[CFG_W-1:0] = config_q;
				DRRCL_OFF_FIRST: prdata[CFG_W-1:0] = first_q;
				DRRCL_OFF_APPLIED: prdata[CFG_W-1:0] = applied_q;
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// Bits 3:0 are per-channel gain, bits 7:4 per-channel span. The word
	// is frozen while a sequence runs so the pins never glitch mid-strobe.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			config_q <= DRRCL_CONFIG_RST;
		else if (wr_en && (paddr == DRRCL_OFF_CONFIG) && !busy)
			config_q <= pwdata[CFG_W-1:0];
	end

	// A command that arrives while busy is dropped and flagged. Writing
	// a one clears a flag, but a new event in that cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refused_q <= 1'b0;
		else if (wr_en && (paddr == DRRCL_OFF_CTRL) && busy)
			refused_q <= 1'b1;
		else if (st_clear && pwdata[DRRCL_ST_REFUSED])
			refused_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done_q <= 1'b0;
		else if (state_q == ST_HOLD && cnt_q == 4'h0)
			done_q <= 1'b1;
		else if (start || (st_clear && pwdata[DRRCL_ST_DONE]))
			done_q <= 1'b0;
	end

	// ==========================================================
	// Strobe sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			cmd_q <= DRRCL_CMD_NONE;
			cnt_q <= DRRCL_CNT_RST;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (start)
					begin
						cmd_q <= wr_cmd;
						state_q <= ST_SETUP;
						cnt_q <= 4'(DRRCL_LEAD_CYC - 1);
					end
				ST_SETUP:
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else
					begin
						state_q <= ST_CS_LOW;
						// Rank select already leads by the setup time,
						// so its low pulse is stretched by that much.
						if (cmd_q == DRRCL_CMD_LOAD_UPDATE)
							cnt_q <= 4'(DRRCL_LS_LOW_CYC);
						else
							cnt_q <= 4'(DRRCL_CS_LOW_CYC - 1);
					end
				ST_CS_LOW:
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else if (cmd_q == DRRCL_CMD_LOAD_UPDATE)
					begin
						state_q <= ST_LS_HIGH;
						cnt_q <= 4'(DRRCL_LS_TO_CS_CYC - 1);
					end
					else
					begin
						state_q <= ST_HOLD;
						cnt_q <= 4'(DRRCL_HOLD_CYC - 1);
					end
				ST_LS_HIGH:
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else
					begin
						state_q <= ST_HOLD;
						cnt_q <= 4'(DRRCL_HOLD_CYC - 1);
					end
				ST_HOLD:
					if (cnt_q != 4'h0)
						cnt_q <= cnt_q - 4'h1;
					else
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin drivers, all from flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			config_word_sel_n <= 1'b1;
			latch_rank_sel_n <= 1'b1;
			device_sel_n <= 1'b1;
			data_out <= '0;
			data_oe <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (start)
					begin
						// Word and selects settle before device select.
						config_word_sel_n <= 1'b0;
						latch_rank_sel_n <=
							(wr_cmd == DRRCL_CMD_UPDATE);
						data_out <= {config_q,
							{(DATA_W-CFG_W){1'b0}}};
						data_oe <= 1'b1;
					end
				ST_SETUP:
					if (cnt_q == 4'h0)
						device_sel_n <= 1'b0;
				ST_CS_LOW:
					if (cnt_q == 4'h0)
					begin
						if (cmd_q == DRRCL_CMD_LOAD_UPDATE)
							latch_rank_sel_n <= 1'b1;
						else
							device_sel_n <= 1'b1;
					end
				ST_LS_HIGH:
					if (cnt_q == 4'h0)
						device_sel_n <= 1'b1;
				ST_HOLD:
					if (cnt_q == 4'h0)
					begin
						// Rank select rises here on preload, device select already high.
						latch_rank_sel_n <= 1'b1;
						config_word_sel_n <= 1'b1;
						data_oe <= 1'b0;
					end
				default:
					device_sel_n <= 1'b1;
			endcase
		end
	end

	// ==========================================================
	// Shadow copies of what each latch rank should now hold
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_q <= DRRCL_CONFIG_RST;
		else if (state_q == ST_SETUP && cnt_q == 4'h0 &&
			cmd_q != DRRCL_CMD_UPDATE)
			first_q <= config_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			applied_q <= DRRCL_CONFIG_RST;
		else if (state_q == ST_HOLD && cnt_q == 4'h0 &&
			cmd_q != DRRCL_CMD_PRELOAD)
			applied_q <= first_q;
	end

	// ==========================================================
	// Checks
	logic [3:0] ls_low_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ls_low_q <= 4'h0;
		else if (latch_rank_sel_n)
			ls_low_q <= 4'h0;
		else if (ls_low_q != 4'hf)
			ls_low_q <= ls_low_q + 4'h1;
	end

	AST_DATA_TOP: assert property (@(posedge pclk) disable iff (!presetn)
		!device_sel_n |-> data_out == {first_q, {(DATA_W-CFG_W){1'b0}}}
			|| cmd_q == DRRCL_CMD_UPDATE)
		else $error("config word not on upper data lines");

	AST_SEL_BEFORE_CS: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(device_sel_n) |-> !$past(config_word_sel_n) && data_oe)
		else $error("word select not low before device select");

	AST_LS_BEFORE_CS: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(device_sel_n) && !latch_rank_sel_n |-> !$past(latch_rank_sel_n))
		else $error("rank select not low before device select");

	AST_CS_AFTER_LS: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(device_sel_n) && cmd_q == DRRCL_CMD_LOAD_UPDATE
			|-> latch_rank_sel_n && $past(latch_rank_sel_n, 4))
		else $error("device select rose too soon after rank select");

	AST_LS_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(latch_rank_sel_n) && cmd_q == DRRCL_CMD_LOAD_UPDATE
			|-> $past(ls_low_q) >= 4'(DRRCL_LS_LOW_CYC + DRRCL_LEAD_CYC))
		else $error("rank select pulse not stretched by its lead");

	AST_PRELOAD_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(latch_rank_sel_n) && cmd_q == DRRCL_CMD_PRELOAD
			|-> device_sel_n && $past(device_sel_n))
		else $error("preload let rank select rise with device select low");

	AST_UPDATE_LS_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		!device_sel_n && cmd_q == DRRCL_CMD_UPDATE |-> latch_rank_sel_n
			&& !config_word_sel_n)
		else $error("update only cycle dropped rank select");

	AST_UPDATE_MOVES: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) && cmd_q != DRRCL_CMD_PRELOAD |-> applied_q == first_q)
		else $error("update did not move first rank into applied");

	AST_BUSY_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
		start |-> ##[8:12] !busy)
		else $error("sequence length out of bounds");

	COV_LOAD_UPDATE: cover property (@(posedge pclk) disable iff (!presetn)
		start && wr_cmd == DRRCL_CMD_LOAD_UPDATE);
	COV_PRELOAD_THEN_UPDATE: cover property (@(posedge pclk)
		disable iff (!presetn)
		$fell(busy) && cmd_q == DRRCL_CMD_PRELOAD ##[1:50]
			start && wr_cmd == DRRCL_CMD_UPDATE);
	COV_REFUSED: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(refused_q));

endmodule

`default_nettype wire

// >>> test/drrcl_latch_model.sv
// Behavioural model of the dual-rank range and gain configuration latch.
// Assumes the host drives the strobes as plain levels with no clock.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Latch model
module drrcl_latch_model
(
	// Pins from the host
	input wire logic [11:0] data_in,
	input wire logic data_oe,
	input wire logic config_word_sel_n,
	input wire logic latch_rank_sel_n,
	input wire logic device_sel_n,
	// Ranks and switch settings
	output logic [7:0] first_q,
	output logic [7:0] second_q,
	output logic [3:0] gain_x2,
	output logic [3:0] span_signed
);
	logic [11:0] bus;
	// A released bus never shows the last word, so a late capture is seen.
	assign bus = data_oe ? data_in : ~data_in;
	initial first_q = 8'h00;
	initial second_q = 8'h00;
	always @*
		if (!config_word_sel_n && !latch_rank_sel_n && !device_sel_n)
			first_q = bus[11:4];
	always @*
		if (!config_word_sel_n && latch_rank_sel_n && !device_sel_n)
			second_q = first_q;
	assign gain_x2 = second_q[3:0];
	assign span_signed = second_q[7:4];
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench: APB register calls drive the host into the model.
// Assumes the host raises pready within 20 cycles of each APB access.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module testbench;
	import drrcl_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [11:0] data_out;
	logic data_oe;
	logic config_word_sel_n;
	logic latch_rank_sel_n;
	logic device_sel_n;
	logic [7:0] first_q;
	logic [7:0] second_q;
	logic [3:0] gain_x2;
	logic [3:0] span_signed;
	logic [31:0] rd;
	logic er;
	logic [3:0] pin_lvl;
	int errors = 0;
	int checks = 0;

	drrcl_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_out(data_out), .data_oe(data_oe),
		.config_word_sel_n(config_word_sel_n),
		.latch_rank_sel_n(latch_rank_sel_n),
		.device_sel_n(device_sel_n));
	drrcl_latch_model dev (.data_in(data_out), .data_oe(data_oe),
		.config_word_sel_n(config_word_sel_n),
		.latch_rank_sel_n(latch_rank_sel_n),
		.device_sel_n(device_sel_n), .first_q(first_q),
		.second_q(second_q), .gain_x2(gain_x2),
		.span_signed(span_signed));

	// Strobe and enable levels gathered for the idle check.
	assign pin_lvl = {config_word_sel_n, latch_rank_sel_n, device_sel_n,
		data_oe};

	always #12.5 pclk = ~pclk;

	task automatic final_report();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One idle edge precedes each setup, so no signal is driven twice.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, DRRCL_OFF_STATUS, 32'h0);
			n++;
		end
		while (rd[DRRCL_ST_BUSY] !== 1'b0 && n < 40);
		if (rd[DRRCL_ST_BUSY] !== 1'b0)
		begin
			errors++;
			final_report();
		end
	endtask

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rchk(DRRCL_OFF_STATUS, 32'h0);
		rchk(DRRCL_OFF_CONFIG, {24'h0, DRRCL_CONFIG_RST});
		rchk(DRRCL_OFF_APPLIED, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, DRRCL_OFF_CONFIG, 32'h0000_00a5);
		apb(1'b1, DRRCL_OFF_CTRL, {30'h0, DRRCL_CMD_LOAD_UPDATE});
		wait_idle();
		chk({24'h0, second_q}, 32'ha5);
		chk({28'h0, gain_x2}, 32'h5);
		chk({28'h0, span_signed}, 32'ha);
		chk({20'h0, data_out}, 32'h0000_0a50);
		chk({28'h0, pin_lvl}, 32'he);
		rchk(DRRCL_OFF_STATUS, 32'h4);
		rchk(DRRCL_OFF_APPLIED, 32'ha5);
		apb(1'b1, DRRCL_OFF_CONFIG, 32'h0000_003c);
		apb(1'b1, DRRCL_OFF_CTRL, {30'h0, DRRCL_CMD_PRELOAD});
		wait_idle();
		chk({24'h0, first_q}, 32'h3c);
		chk({24'h0, second_q}, 32'ha5);
		rchk(DRRCL_OFF_FIRST, 32'h3c);
		apb(1'b1, DRRCL_OFF_CTRL, {30'h0, DRRCL_CMD_UPDATE});
		wait_idle();
		chk({24'h0, second_q}, 32'h3c);
		apb(1'b1, DRRCL_OFF_CONFIG, 32'h0000_000f);
		apb(1'b1, DRRCL_OFF_CTRL, {30'h0, DRRCL_CMD_LOAD_UPDATE});
		apb(1'b1, DRRCL_OFF_CONFIG, 32'h0000_0055);
		apb(1'b1, DRRCL_OFF_CTRL, {30'h0, DRRCL_CMD_PRELOAD});
		wait_idle();
		rchk(DRRCL_OFF_STATUS, 32'h6);
		rchk(DRRCL_OFF_CTRL, 32'h1);
		rchk(DRRCL_OFF_CONFIG, 32'h0f);
		chk({24'h0, second_q}, 32'h0f);
		chk({28'h0, pin_lvl}, 32'he);
		apb(1'b1, DRRCL_OFF_CTRL, {30'h0, DRRCL_CMD_NONE});
		apb(1'b1, DRRCL_OFF_STATUS, 32'h2);
		rchk(DRRCL_OFF_STATUS, 32'h4);
		rchk(DRRCL_OFF_CTRL, 32'h1);
		apb(1'b1, 8'h40, 32'h0000_0006);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, DRRCL_OFF_STATUS, 32'h4);
		rchk(DRRCL_OFF_STATUS, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
